// ---- inc/ingress_policing_pkg.sv ----
// Constants and types shared by the ingress policing configuration block
package ingress_policing_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_THROTTLE   = 16'h1848;
    localparam logic [15:0] IDX_ADMIT      = 16'h1849;
    localparam logic [15:0] IDX_METER_CFG  = 16'h184a;
    localparam logic [15:0] IDX_METER_CMD  = 16'h184b;
    localparam logic [15:0] IDX_CMD_STATUS = 16'h184c;
    localparam logic [15:0] IDX_WRITE_VAL  = 16'h184d;
    localparam logic [15:0] IDX_READ_VAL   = 16'h184e;
    localparam logic [15:0] ADDR_THROTTLE   = {IDX_THROTTLE[13:0], 2'b00};
    localparam logic [15:0] ADDR_ADMIT      = {IDX_ADMIT[13:0], 2'b00};
    localparam logic [15:0] ADDR_METER_CFG  = {IDX_METER_CFG[13:0], 2'b00};
    localparam logic [15:0] ADDR_METER_CMD  = {IDX_METER_CMD[13:0], 2'b00};
    localparam logic [15:0] ADDR_CMD_STATUS = {IDX_CMD_STATUS[13:0], 2'b00};
    localparam logic [15:0] ADDR_WRITE_VAL  = {IDX_WRITE_VAL[13:0], 2'b00};
    localparam logic [15:0] ADDR_READ_VAL   = {IDX_READ_VAL[13:0], 2'b00};

    // Broadcast throttle layout: nine bits per port, level low, enable on top
    localparam int          NUM_PORTS        = 3;
    localparam int          THROTTLE_W       = 27;
    localparam int          THROTTLE_STRIDE  = 9;
    localparam int          THROTTLE_EN_OFS  = 8;
    localparam logic [26:0] THROTTLE_RESET   = 27'h0080402;
    localparam int          BUDGET_SHIFT     = 6;
    localparam int          BUDGET_W         = 14;

    // Meter configuration layout
    localparam int          CFG_ENABLE_BIT = 0;
    localparam int          CFG_MODE_LSB   = 1;
    localparam logic [2:0]  CFG_RESET      = 3'h0;

    // Command layout
    localparam int          CMD_DIR_BIT   = 7;
    localparam int          CMD_TYPE_LSB  = 5;
    localparam int          CMD_ADDR_LSB  = 0;
    localparam logic [7:0]  CMD_RESET     = 8'h00;

    // Metering table
    localparam int          RATE_ENTRIES  = 24;
    localparam logic [4:0]  RATE_LAST     = 5'h17;
    localparam logic [15:0] RATE_RESET    = 16'h0014;
    localparam logic [15:0] BURST_RESET   = 16'h0600;
    localparam logic [15:0] VALUE_RESET   = 16'h0000;

    // Broadcast interval timing
    localparam int          CLK_PERIOD_NS     = 40;
    localparam int          BCAST_INTERVAL_NS = 1720000;
    localparam int          BCAST_INTERVAL_CYCLES = BCAST_INTERVAL_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MODE_PORT_PRIO = 2'b00,
        MODE_PORT_ONLY = 2'b01,
        MODE_PRIO_ONLY = 2'b10,
        MODE_RESERVED  = 2'b11
    } meter_mode_t;

    typedef enum logic [1:0] {
        TYPE_RESERVED  = 2'b00,
        TYPE_RATE      = 2'b01,
        TYPE_COMMITTED = 2'b10,
        TYPE_EXCESS    = 2'b11
    } table_sel_t;

    // Gray order along idle -> busy -> finish
    typedef enum logic [1:0] {
        CMD_IDLE   = 2'b00,
        CMD_BUSY   = 2'b01,
        CMD_FINISH = 2'b11
    } cmd_state_t;

endpackage

// ---- logic/bcast_throttle_port.sv ----
// Broadcast byte budget for one switch port
`timescale 1ns/1ps
`default_nettype none
module bcast_throttle_port (
    input  wire logic                                     clk_i,
    input  wire logic                                     reset_i,
    input  wire logic                                     tick_i,
    input  wire logic                                     enable_i,
    input  wire logic [7:0]                               level_i,
    input  wire logic                                     byte_i,
    output logic                                          hold_o
);
    import ingress_policing_pkg::*;

    logic [BUDGET_W-1:0] used;
    logic [BUDGET_W-1:0] budget;

    // Budget is the level in units of 64 bytes
    assign budget = {level_i, {BUDGET_SHIFT{1'b0}}};

    // Bytes taken this interval; a new interval starts from zero
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            used <= '0;
        end else if (tick_i) begin
            used <= '0;
        end else if (byte_i && !hold_o) begin
            used <= used + 1'b1;
        end
    end

    // Hold back further broadcast input once the budget is spent
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            hold_o <= 1'b0;
        end else begin
            hold_o <= enable_i && (used >= budget) && !tick_i;
        end
    end

    property p_hold_spent;
        @(posedge clk_i) disable iff (reset_i)
        (enable_i && used >= budget && !tick_i) |=> hold_o;
    endproperty
    a_hold_spent: assert property (p_hold_spent) else $error("budget spent but input not held");

endmodule
`default_nettype wire

// ---- logic/ingress_policing_config.sv ----
// Ingress policing configuration, admission check and metering table access
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - One broadcast throttle enable per port at bits 26, 17, 8; reset off.
// - Per-port 8-bit level allows level times 64 bytes per 1.72 ms; reset 2.
// - Three admit bits let a port send to VLANs it is not member of.
// - Non-member admission still needs the destination VLAN active.
// - Rate enable bit 0 turns ingress metering, colouring and dropping on in every mode but reserved.
// - Mode bits 2:1: port+priority, port only, priority only, reserved.
// - A command register write while the sequencer is idle launches the described table access unless the mode or the type is reserved.
// - Command bit 7 set reads, clear writes; resets to write.
// - Type bits 6:5 select rate entry, committed burst or excess burst.
// - Address bits 4:0 choose one of 24 rate entries.
// - Port+priority mode uses eight entries per port, priority 0 lowest.
// - Port-only mode uses entry equal to the port number.
// - Priority-only mode uses entry equal to the priority.
// - Read result is loaded before the pending flag clears.
// - Table holds 24 rate entries and two burst sizes, 16 bits each.
// - Pending flag is set during an access and clears itself.
// - Rate entries mean time per byte of value plus one times 20 ns; reset 14h.
// - Both burst sizes reset to 600h and steer the dropping datapath.
module ingress_policing_config #(
    parameter int                                         INTERVAL_CYCLES = ingress_policing_pkg::BCAST_INTERVAL_CYCLES
) (
    input  wire logic                                     clk_i,
    input  wire logic                                     reset_i,
    input  wire logic [15:0]                              addr_i,
    input  wire logic [31:0]                              wdata_i,
    input  wire logic                                     wr_i,
    input  wire logic                                     rd_i,
    output logic      [31:0]                              rdata_o,
    input  wire logic [ingress_policing_pkg::NUM_PORTS-1:0] bcast_byte_i,
    output logic      [ingress_policing_pkg::NUM_PORTS-1:0] bcast_hold_o,
    input  wire logic                                     adm_check_i,
    input  wire logic [1:0]                               adm_port_i,
    input  wire logic                                     adm_member_i,
    input  wire logic                                     adm_vlan_active_i,
    output logic                                          adm_accept_o,
    input  wire logic [1:0]                               meter_port_i,
    input  wire logic [4:0]                               meter_prio_i,
    output logic                                          meter_active_o,
    output ingress_policing_pkg::meter_mode_t             meter_mode_o,
    output logic      [15:0]                              rate_entry_o,
    output logic      [15:0]                              committed_burst_o,
    output logic      [15:0]                              excess_burst_o
);
    import ingress_policing_pkg::*;

    logic [THROTTLE_W-1:0] throttle_ctrl;
    logic [2:0]            admit_ctrl;
    logic [2:0]            meter_cfg;
    logic [7:0]            meter_cmd;
    logic [15:0]           write_value;
    logic [15:0]           read_value;
    logic [15:0]           rate_table [RATE_ENTRIES];
    logic                  pending;
    cmd_state_t            state;
    logic [15:0]           interval_cnt;
    logic                  interval_tick;
    logic                  cmd_launch;
    logic [4:0]            cmd_addr;
    table_sel_t            cmd_sel;
    meter_mode_t           cfg_mode;
    logic                  cmd_legal;
    logic [4:0]            next_index;
    logic [31:0]           next_rdata;

    assign cmd_addr  = meter_cmd[CMD_ADDR_LSB +: 5];
    assign cmd_sel   = table_sel_t'(meter_cmd[CMD_TYPE_LSB +: 2]);
    assign cfg_mode  = meter_mode_t'(meter_cfg[CFG_MODE_LSB +: 2]);
    // Reserved selector or mode leaves the table alone
    assign cmd_legal = (cmd_sel != TYPE_RESERVED) && (cfg_mode != MODE_RESERVED);
    // A command write while one is still running is dropped; software waits
    assign cmd_launch = wr_i && (addr_i == ADDR_METER_CMD) && (state == CMD_IDLE);

    // Plain software registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            throttle_ctrl <= THROTTLE_RESET;
            admit_ctrl    <= 3'h0;
            meter_cfg     <= CFG_RESET;
            write_value   <= VALUE_RESET;
        end else if (wr_i) begin
            case (addr_i)
                ADDR_THROTTLE:  throttle_ctrl <= wdata_i[THROTTLE_W-1:0];
                ADDR_ADMIT:     admit_ctrl    <= wdata_i[2:0];
                ADDR_METER_CFG: meter_cfg     <= wdata_i[2:0];
                ADDR_WRITE_VAL: write_value   <= wdata_i[15:0];
                default:        ;
            endcase
        end
    end

    // Command register captured only when an access is launched
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meter_cmd <= CMD_RESET;
        end else if (cmd_launch) begin
            meter_cmd <= wdata_i[7:0];
        end
    end

    // Command sequencer: one cycle to act, one to finish
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= CMD_IDLE;
        end else begin
            case (state)
                CMD_IDLE:   state <= cmd_launch ? CMD_BUSY : CMD_IDLE;
                CMD_BUSY:   state <= CMD_FINISH;
                CMD_FINISH: state <= CMD_IDLE;
                default:    state <= CMD_IDLE;
            endcase
        end
    end

    // Pending flag follows the sequencer and clears on its own
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pending <= 1'b0;
        end else if (cmd_launch) begin
            pending <= 1'b1;
        end else if (state == CMD_FINISH) begin
            pending <= 1'b0;
        end
    end

    // Table writes; out-of-range rate addresses are simply dropped
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < RATE_ENTRIES; i++) begin
                rate_table[i] <= RATE_RESET;
            end
            committed_burst_o <= BURST_RESET;
            excess_burst_o    <= BURST_RESET;
        end else if (state == CMD_BUSY && !meter_cmd[CMD_DIR_BIT] && cmd_legal) begin
            case (cmd_sel)
                TYPE_RATE: begin
                    if (cmd_addr <= RATE_LAST) begin
                        rate_table[cmd_addr] <= write_value;
                    end
                end
                TYPE_COMMITTED: committed_burst_o <= write_value;
                TYPE_EXCESS:    excess_burst_o    <= write_value;
                default:        ;
            endcase
        end
    end

    // Read result lands in the busy cycle, before pending drops
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            read_value <= VALUE_RESET;
        end else if (state == CMD_BUSY && meter_cmd[CMD_DIR_BIT] && cmd_legal) begin
            case (cmd_sel)
                TYPE_RATE:      read_value <= (cmd_addr <= RATE_LAST) ? rate_table[cmd_addr] : VALUE_RESET;
                TYPE_COMMITTED: read_value <= committed_burst_o;
                TYPE_EXCESS:    read_value <= excess_burst_o;
                default:        read_value <= read_value;
            endcase
        end
    end

    // Read mux; unmapped addresses and reserved bits read as zero
    always_comb begin
        next_rdata = 32'h0;
        case (addr_i)
            ADDR_THROTTLE:   next_rdata[THROTTLE_W-1:0] = throttle_ctrl;
            ADDR_ADMIT:      next_rdata[2:0]  = admit_ctrl;
            ADDR_METER_CFG:  next_rdata[2:0]  = meter_cfg;
            ADDR_METER_CMD:  next_rdata[7:0]  = meter_cmd;
            ADDR_CMD_STATUS: next_rdata[0]    = pending;
            ADDR_WRITE_VAL:  next_rdata[15:0] = write_value;
            ADDR_READ_VAL:   next_rdata[15:0] = read_value;
            default:         next_rdata = 32'h0;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 32'h0;
        end else begin
            rdata_o <= rd_i ? next_rdata : 32'h0;
        end
    end

    // Interval divider; the tick restarts every port's budget together
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            interval_cnt  <= 16'h0;
            interval_tick <= 1'b0;
        end else if (interval_cnt == 16'(INTERVAL_CYCLES - 1)) begin
            interval_cnt  <= 16'h0;
            interval_tick <= 1'b1;
        end else begin
            interval_cnt  <= interval_cnt + 16'h1;
            interval_tick <= 1'b0;
        end
    end

    // One budget keeper per port
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        bcast_throttle_port u_throttle (
            .clk_i    (clk_i),
            .reset_i  (reset_i),
            .tick_i   (interval_tick),
            .enable_i (throttle_ctrl[p*THROTTLE_STRIDE + THROTTLE_EN_OFS]),
            .level_i  (throttle_ctrl[p*THROTTLE_STRIDE +: 8]),
            .byte_i   (bcast_byte_i[p]),
            .hold_o   (bcast_hold_o[p])
        );
    end

    // Admission: member or admitted non-member, VLAN must be active
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            adm_accept_o <= 1'b0;
        end else begin
            adm_accept_o <= adm_check_i && adm_vlan_active_i &&
                            (adm_member_i || (adm_port_i != 2'h3 && admit_ctrl[adm_port_i]));
        end
    end

    // Entry selection by mode
    always_comb begin
        next_index = 5'h0;
        case (cfg_mode)
            MODE_PORT_PRIO: next_index = {meter_port_i, meter_prio_i[2:0]};
            MODE_PORT_ONLY: next_index = {3'h0, meter_port_i};
            MODE_PRIO_ONLY: next_index = meter_prio_i;
            default:        next_index = 5'h0;
        endcase
    end

    // Metering controls handed to the datapath
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meter_active_o <= 1'b0;
            meter_mode_o   <= MODE_PORT_PRIO;
            rate_entry_o   <= RATE_RESET;
        end else begin
            meter_active_o <= meter_cfg[CFG_ENABLE_BIT] && (cfg_mode != MODE_RESERVED);
            meter_mode_o   <= cfg_mode;
            rate_entry_o   <= (next_index <= RATE_LAST) ? rate_table[next_index] : VALUE_RESET;
        end
    end

    property p_launch_pending;
        @(posedge clk_i) disable iff (reset_i)
        cmd_launch |=> pending ##1 pending ##1 !pending;
    endproperty
    a_launch_pending: assert property (p_launch_pending) else $error("pending did not span the access");

    property p_launch_state;
        @(posedge clk_i) disable iff (reset_i)
        cmd_launch |=> state == CMD_BUSY;
    endproperty
    a_launch_state: assert property (p_launch_state) else $error("command write did not start access");

    property p_read_ready;
        @(posedge clk_i) disable iff (reset_i)
        (state == CMD_BUSY && meter_cmd[CMD_DIR_BIT] && cmd_legal && cmd_sel == TYPE_COMMITTED)
        |=> read_value == committed_burst_o && pending;
    endproperty
    a_read_ready: assert property (p_read_ready) else $error("read value missing before pending clears");

    property p_read_hold;
        @(posedge clk_i) disable iff (reset_i)
        !(state == CMD_BUSY && meter_cmd[CMD_DIR_BIT]) |=> $stable(read_value);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read value changed without read command");

    property p_reserved_quiet;
        @(posedge clk_i) disable iff (reset_i)
        (state == CMD_BUSY && !cmd_legal) |=> $stable(committed_burst_o) && $stable(excess_burst_o);
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved command touched table");

    property p_accept_vlan;
        @(posedge clk_i) disable iff (reset_i)
        adm_accept_o |-> $past(adm_vlan_active_i) && $past(adm_check_i);
    endproperty
    a_accept_vlan: assert property (p_accept_vlan) else $error("accepted with inactive VLAN");

    property p_meter_enable;
        @(posedge clk_i) disable iff (reset_i)
        ##1 meter_active_o == ($past(meter_cfg[CFG_ENABLE_BIT]) && $past(cfg_mode) != MODE_RESERVED);
    endproperty
    a_meter_enable: assert property (p_meter_enable) else $error("metering enable mismatch");

    property p_prio_lookup;
        @(posedge clk_i) disable iff (reset_i)
        (cfg_mode == MODE_PRIO_ONLY && meter_prio_i <= RATE_LAST) |=> rate_entry_o == rate_table[$past(meter_prio_i)];
    endproperty
    a_prio_lookup: assert property (p_prio_lookup) else $error("priority-only lookup wrong");

    property p_rdata_cfg;
        @(posedge clk_i) disable iff (reset_i)
        (rd_i && addr_i == ADDR_METER_CFG) |=> rdata_o == {29'h0, $past(meter_cfg)} ##1 (rdata_o == 32'h0 || $past(rd_i));
    endproperty
    a_rdata_cfg: assert property (p_rdata_cfg) else $error("configuration read back wrong");

endmodule
`default_nettype wire

// ---- bench/test_ingress_policing_config.sv ----
// Self-checking testbench for the ingress policing configuration block
`timescale 1ns/1ps
`default_nettype none
module test_ingress_policing_config;
    import ingress_policing_pkg::*;
    localparam int INTERVAL = 200;   // Short interval keeps the throttle test brief
    logic        clk_i;
    logic        reset_i;
    logic [15:0] addr_i;
    logic [31:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [31:0] rdata_o;
    logic [2:0]  bcast_byte_i;
    logic [2:0]  bcast_hold_o;
    logic        adm_check_i;
    logic [1:0]  adm_port_i;
    logic        adm_member_i;
    logic        adm_vlan_active_i;
    logic        adm_accept_o;
    logic [1:0]  meter_port_i;
    logic [4:0]  meter_prio_i;
    logic        meter_active_o;
    meter_mode_t meter_mode_o;
    logic [15:0] rate_entry_o;
    logic [15:0] committed_burst_o;
    logic [15:0] excess_burst_o;
    int          err_total;
    int          cmp_count;
    int          n;

    ingress_policing_config #(.INTERVAL_CYCLES(INTERVAL)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .bcast_byte_i(bcast_byte_i), .bcast_hold_o(bcast_hold_o),
        .adm_check_i(adm_check_i), .adm_port_i(adm_port_i), .adm_member_i(adm_member_i),
        .adm_vlan_active_i(adm_vlan_active_i), .adm_accept_o(adm_accept_o), .meter_port_i(meter_port_i),
        .meter_prio_i(meter_prio_i), .meter_active_o(meter_active_o), .meter_mode_o(meter_mode_o),
        .rate_entry_o(rate_entry_o), .committed_burst_o(committed_burst_o), .excess_burst_o(excess_burst_o));

    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // Case equality so an unknown never counts as a match
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe, launched right after an edge
    task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(what, exp, rdata_o);
    endtask

    // Launch a table access, see pending rise, then wait for it to drop
    task automatic table_cmd(input logic [7:0] cmd);
        reg_wr(ADDR_METER_CMD, {24'h0, cmd});
        rd_chk("pending set", ADDR_CMD_STATUS, 32'h1);
        n = 0;
        // Every poll, the first included, must already see the flag cleared
        while (rdata_o !== 32'h0 && n < 20) begin
            rd_chk("pending poll", ADDR_CMD_STATUS, 32'h0);
            n++;
        end
        chk("pending cleared", 32'h0, rdata_o);
    endtask

    task automatic tbl_wr(input logic [6:0] sel, input logic [15:0] d);
        reg_wr(ADDR_WRITE_VAL, {16'h0, d});
        table_cmd({1'b0, sel});
    endtask

    task automatic tbl_rd(input logic [6:0] sel, input logic [15:0] exp);
        table_cmd({1'b1, sel});
        rd_chk("table read", ADDR_READ_VAL, {16'h0, exp});
    endtask

    // Program mode and enable, present keys, check the selected entry
    task automatic lookup(input logic en, input logic [1:0] mode, input logic [1:0] port,
                          input logic [4:0] prio, input logic [15:0] exp);
        reg_wr(ADDR_METER_CFG, {29'h0, mode, en});
        @(posedge clk_i);
        meter_port_i <= port;
        meter_prio_i <= prio;
        repeat (2) @(posedge clk_i);
        #1;
        chk("rate entry", {16'h0, exp}, {16'h0, rate_entry_o});
        chk("meter active", {31'h0, en & (mode != 2'b11)}, {31'h0, meter_active_o});
        chk("meter mode", {30'h0, mode}, {30'h0, meter_mode_o});
    endtask

    // One admission query, answer is looked at in the cycle after it
    task automatic adm(input logic [1:0] port, input logic member, input logic act, input logic exp);
        @(posedge clk_i);
        adm_check_i       <= 1'b1;
        adm_port_i        <= port;
        adm_member_i      <= member;
        adm_vlan_active_i <= act;
        @(posedge clk_i);
        adm_check_i <= 1'b0;
        #1;
        chk("admit accept", {31'h0, exp}, {31'h0, adm_accept_o});
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog: whole sequence needs well under 10000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        {addr_i, wdata_i, wr_i, rd_i, bcast_byte_i, adm_check_i, adm_port_i} = '0;
        {adm_member_i, adm_vlan_active_i, meter_port_i, meter_prio_i} = '0;
        err_total = 0;
        cmp_count = 0;
        reset_i   = 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rd_chk("throttle", ADDR_THROTTLE, 32'h0008_0402);
        rd_chk("admit", ADDR_ADMIT, 32'h0);
        rd_chk("meter cfg", ADDR_METER_CFG, 32'h0);
        rd_chk("command", ADDR_METER_CMD, 32'h0);
        rd_chk("status", ADDR_CMD_STATUS, 32'h0);
        rd_chk("read value", ADDR_READ_VAL, 32'h0);
        rd_chk("unmapped", 16'h0100, 32'h0);
        chk("committed out", 32'h0600, {16'h0, committed_burst_o});
        chk("excess out", 32'h0600, {16'h0, excess_burst_o});
        $display("test reset values done");
        // Unused bits read zero; read value is not writable
        reg_wr(ADDR_THROTTLE, 32'hffff_ffff);
        rd_chk("throttle all", ADDR_THROTTLE, 32'h07ff_ffff);
        reg_wr(ADDR_ADMIT, 32'hffff_ffff);
        rd_chk("admit all", ADDR_ADMIT, 32'h7);
        reg_wr(ADDR_METER_CFG, 32'hffff_ffff);
        rd_chk("cfg all", ADDR_METER_CFG, 32'h7);
        reg_wr(ADDR_READ_VAL, 32'h1234);
        rd_chk("read value ro", ADDR_READ_VAL, 32'h0);
        // Mode is reserved now, so this burst write must not land
        tbl_wr(7'h40, 16'h7777);
        reg_wr(ADDR_METER_CFG, 32'h0);
        $display("test register access done");
        // Every rate entry and both bursts at their reset value
        for (int i = 0; i < 24; i++) begin
            tbl_rd({2'b01, 5'(i)}, 16'h0014);
        end
        tbl_rd(7'h40, 16'h0600);
        tbl_rd(7'h60, 16'h0600);
        tbl_wr({2'b01, 5'd23}, 16'hbeef);
        tbl_wr({2'b01, 5'd0}, 16'h1111);
        tbl_wr({2'b01, 5'd13}, 16'h0d0d);
        tbl_wr({2'b01, 5'd2}, 16'h0202);
        tbl_wr({2'b01, 5'd20}, 16'h2020);
        tbl_wr(7'h40, 16'h0123);
        tbl_wr(7'h60, 16'h0456);
        tbl_rd({2'b01, 5'd23}, 16'hbeef);
        tbl_rd(7'h40, 16'h0123);
        tbl_rd(7'h60, 16'h0456);
        chk("committed out", 32'h0123, {16'h0, committed_burst_o});
        chk("excess out", 32'h0456, {16'h0, excess_burst_o});
        // Reserved type leaves table and read value alone
        tbl_wr({2'b00, 5'd13}, 16'h9999);
        tbl_rd({2'b01, 5'd13}, 16'h0d0d);
        table_cmd(8'h8d);
        rd_chk("read value kept", ADDR_READ_VAL, 32'h0d0d);
        $display("test metering table done");
        lookup(1'b1, 2'b00, 2'd1, 5'd5, 16'h0d0d);
        lookup(1'b1, 2'b00, 2'd2, 5'd0, 16'h0014);
        lookup(1'b1, 2'b01, 2'd2, 5'd7, 16'h0202);
        lookup(1'b1, 2'b10, 2'd1, 5'd20, 16'h2020);
        lookup(1'b1, 2'b10, 2'd0, 5'd23, 16'hbeef);
        lookup(1'b1, 2'b11, 2'd0, 5'd3, 16'h1111);
        lookup(1'b0, 2'b00, 2'd0, 5'd0, 16'h1111);
        $display("test rate lookup done");
        reg_wr(ADDR_ADMIT, 32'h2);
        adm(2'd1, 1'b0, 1'b1, 1'b1);
        adm(2'd1, 1'b0, 1'b0, 1'b0);
        adm(2'd0, 1'b0, 1'b1, 1'b0);
        adm(2'd2, 1'b0, 1'b1, 1'b0);
        adm(2'd0, 1'b1, 1'b1, 1'b1);
        reg_wr(ADDR_ADMIT, 32'h5);
        adm(2'd2, 1'b0, 1'b1, 1'b1);
        adm(2'd1, 1'b0, 1'b1, 1'b0);
        $display("test admission done");
        // Port 0 on at level 1, port 1 off at level 1: budget 64 bytes
        reg_wr(ADDR_THROTTLE, 32'h0008_0301);
        n = 0;
        while (bcast_hold_o[0] !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            bcast_byte_i <= 3'b011;
            #1;
            n++;
        end
        @(posedge clk_i);
        bcast_byte_i <= 3'b000;
        n = 0;
        while (bcast_hold_o[0] !== 1'b0 && n < INTERVAL + 10) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("hold released", 32'h0, {29'h0, bcast_hold_o});
        // Fresh interval: 63 bytes pass, the 64th exhausts the budget
        repeat (63) begin
            @(posedge clk_i);
            bcast_byte_i <= 3'b011;
        end
        @(posedge clk_i);
        bcast_byte_i <= 3'b000;
        repeat (3) @(posedge clk_i);
        #1;
        chk("hold under budget", 32'h0, {29'h0, bcast_hold_o});
        @(posedge clk_i);
        bcast_byte_i <= 3'b011;
        @(posedge clk_i);
        bcast_byte_i <= 3'b000;
        repeat (2) @(posedge clk_i);
        #1;
        chk("hold at budget", 32'h1, {29'h0, bcast_hold_o});
        $display("test broadcast throttle done");
        conclude();
    end
endmodule
`default_nettype wire
